//--- hw/crc_snoop.sv
// Sixteen-bit CRC unit with passive peripheral bus snoop
`timescale 1ns/10ps
`default_nettype none

// Pipeline in brief:
//   edge 1: an explicit byte or a snooped byte is captured into the input
//           byte register and marked pending.
//   edge 2: the pending byte is folded into the result through eight
//           single-bit steps, all in one cycle.
// A seed write in the same cycle as a fold wins; the pending byte is lost.
// An explicit byte write wins over a snoop hit in the same cycle, so the
// snooped byte is lost in that case; software must not mix both sources.
// The bus is only observed: nothing here can stall or change a transfer.
// Bit order and polynomial are levels read at fold time, so they must not
// change while a byte is pending.

// What this block does
// - Polynomial choice: CCITT x16+x12+x5+1 or CRC-16 x16+x15+x2+1.
// - Sixteen-bit checksum, updated with exactly one byte each time.
// - Software seeds the result, then each input byte updates it.
// - Update for one byte finishes within two machine cycles.
// - Top two target bits separately enable read and write snooping.
// - Write snoop on target address captures written byte, then updates.
// - Read snoop on target address captures returned byte, then updates.
// - Word cycles snoop only the target byte lane, other byte ignored.
// - Snoop targets limited to USB, UART and serial sound registers; the decode matches any bus address.
module crc_snoop
  import crc_snoop_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Configuration
  input  wire logic              poly_crc16_i,
  input  wire logic              msb_first_i,
  input  wire logic [ADDR_W+1:0] snoop_target_address_i,
  // Seed and explicit input
  input  wire logic              seed_we_i,
  input  wire logic [15:0]       seed_i,
  input  wire logic              byte_we_i,
  input  wire logic [7:0]        byte_i,
  // Observed bus traffic
  input  wire bus_obs_t          bus_i,
  // Status
  output logic [15:0]            checksum_result_o,
  output logic [7:0]             checksum_input_byte_o,
  output logic                   busy_o
);
  // Synchronised reset
  logic        rst_s1;
  logic        rst_n;

  // Result, captured byte and pending fold
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic [7:0]  in_byte;
  logic [7:0]  next_in_byte;
  pend_t       pend;
  pend_t       next_pend;

  // Snoop decode results
  logic        dir_enable;
  logic        lane_low;
  logic        lane_high;
  logic        snoop_hit;
  logic [7:0]  snoop_byte;

  // Polynomial and its bit-reversed copy
  logic [15:0] poly;
  logic [15:0] poly_rev;

  // Per-bit CRC chains, one per shift direction
  logic [15:0] chain_msb [0:8];
  logic [15:0] chain_lsb [0:8];
  logic [15:0] fold_crc;

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Generator polynomial select
  assign poly = poly_crc16_i ? POLY_CRC16 : POLY_CCITT;

  // Reflected polynomial for LSB-first shifting
  for (genvar k = 0; k < 16; k++) begin : g_rev
    assign poly_rev[k] = poly[15-k];
  end

  // Eight single-bit steps fold one byte in one cycle
  assign chain_msb[0] = crc;
  assign chain_lsb[0] = crc;
  for (genvar b = 0; b < 8; b++) begin : g_step
    logic fb_msb;
    logic fb_lsb;
    assign fb_msb         = chain_msb[b][15] ^ pend.data[7-b];
    assign fb_lsb         = chain_lsb[b][0] ^ pend.data[b];
    assign chain_msb[b+1] = {chain_msb[b][14:0], 1'b0} ^ (fb_msb ? poly : 16'h0000);
    assign chain_lsb[b+1] = {1'b0, chain_lsb[b][15:1]} ^ (fb_lsb ? poly_rev : 16'h0000);
  end

  // Bit order pick; both chains always run
  assign fold_crc = msb_first_i ? chain_msb[8] : chain_lsb[8];

  // Direction enable from the two top target bits
  always_comb begin
    dir_enable = 1'b0;
    if (bus_i.write) begin
      dir_enable = snoop_target_address_i[WR_EN_BIT];
    end else begin
      dir_enable = snoop_target_address_i[RD_EN_BIT];
    end
  end

  // Lane match: low byte at addr, high byte at addr+1 on word cycles
  // Any bus address is decoded; targets outside the peripheral window are software misuse
  always_comb begin
    lane_low  = 1'b0;
    lane_high = 1'b0;
    if (bus_i.addr == snoop_target_address_i[ADDR_W-1:0]) begin
      lane_low = 1'b1;
    end else if (bus_i.word && (bus_i.addr + ADDR_W'(1)) == snoop_target_address_i[ADDR_W-1:0]) begin
      lane_high = 1'b1;
    end
  end

  // Snoop capture: passive observation only, bus never driven
  always_comb begin
    snoop_hit  = 1'b0;
    snoop_byte = 8'h00;
    if (bus_i.valid && dir_enable) begin
      if (lane_low) begin
        snoop_hit  = 1'b1;
        snoop_byte = bus_i.data[7:0];
      end else if (lane_high) begin
        snoop_hit  = 1'b1;
        snoop_byte = bus_i.data[15:8];
      end
    end
  end

  // Next state: capture byte, fold one cycle later
  always_comb begin
    next_crc     = crc;
    next_in_byte = in_byte;
    next_pend    = '{busy: 1'b0, data: pend.data};
    if (pend.busy) begin
      next_crc = fold_crc;
    end
    if (seed_we_i) begin
      next_crc = seed_i;
    end
    if (byte_we_i) begin
      next_in_byte = byte_i;
      next_pend    = '{busy: 1'b1, data: byte_i};
    end else if (snoop_hit) begin
      next_in_byte = snoop_byte;
      next_pend    = '{busy: 1'b1, data: snoop_byte};
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      crc     <= RESULT_RESET;
      in_byte <= 8'h00;
      pend    <= '{busy: 1'b0, data: 8'h00};
    end else begin
      crc     <= next_crc;
      in_byte <= next_in_byte;
      pend    <= next_pend;
    end
  end

  // Outputs straight from registers
  assign checksum_result_o     = crc;
  assign checksum_input_byte_o = in_byte;
  assign busy_o                = pend.busy;
endmodule
`default_nettype wire

//--- include/crc_snoop_pkg.sv
// Constants and carrier types for the snooping CRC unit
package crc_snoop_pkg;
  localparam int          ADDR_W        = 10;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [15:0] POLY_CCITT    = 16'h1021;
  localparam logic [15:0] POLY_CRC16    = 16'h8005;
  localparam int          UPDATE_CYCLES = 2;
  localparam int          RD_EN_BIT     = ADDR_W + 1;
  localparam int          WR_EN_BIT     = ADDR_W;

  // One observed peripheral bus transfer
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              word;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } bus_obs_t;

  // Byte waiting to be folded into the checksum
  typedef struct packed {
    logic       busy;
    logic [7:0] data;
  } pend_t;
endpackage

//--- test/crc_snoop_props.sv
// Port checker for the snooping CRC unit
`timescale 1ns/10ps
`default_nettype none
module crc_snoop_props
  import crc_snoop_pkg::*;
(
  input wire logic ref_clk_i, rst_n_i, seed_we_i, byte_we_i, busy_o,
  input wire logic [ADDR_W+1:0] snoop_target_address_i,
  input wire logic [15:0] seed_i, checksum_result_o,
  input wire logic [7:0] byte_i, checksum_input_byte_o,
  input wire bus_obs_t bus_i
);
  // Address match, upper lane, enable and no competing source
  wire logic hit = bus_i.valid && bus_i.addr == snoop_target_address_i[9:0];
  wire logic hil = bus_i.valid && bus_i.word && bus_i.addr + 10'h001 == snoop_target_address_i[9:0];
  wire logic en = bus_i.write ? snoop_target_address_i[WR_EN_BIT] : snoop_target_address_i[RD_EN_BIT];
  wire logic fr = !byte_we_i && !seed_we_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_seed_load: assert property (seed_we_i |=> checksum_result_o == $past(seed_i))
    else $error("seed not loaded");
  a_byte_take: assert property (byte_we_i && !seed_we_i |=> busy_o && checksum_input_byte_o == $past(byte_i))
    else $error("byte not taken");
  a_wr_snoop: assert property (hit && en && bus_i.write && fr |=> checksum_input_byte_o == $past(bus_i.data[7:0]))
    else $error("write snoop");
  a_rd_snoop: assert property (hit && en && !bus_i.write && fr |=> checksum_input_byte_o == $past(bus_i.data[7:0]))
    else $error("read snoop");
  a_hi_lane: assert property (hil && en && fr |=> checksum_input_byte_o == $past(bus_i.data[15:8]))
    else $error("wrong lane");
  a_snoop_off: assert property (bus_i.valid && !en && fr |=> !busy_o)
    else $error("disabled snoop");
  a_result_hold: assert property (!busy_o && !seed_we_i |=> $stable(checksum_result_o))
    else $error("result moved");
  a_no_source: assert property (!byte_we_i && !bus_i.valid |=> !busy_o)
    else $error("busy without byte");
  c_word: cover property (hil && en);
  c_wr: cover property (hit && en && bus_i.write);
  c_rd: cover property (hit && en && !bus_i.write);
endmodule
`default_nettype wire

//--- test/crc_bus_model.sv
// Behavioural CPU or DMA master on the watched bus
`timescale 1ns/10ps
`default_nettype none
module crc_bus_model
  import crc_snoop_pkg::*;
(
  input  wire logic     ref_clk_i,
  input  wire bus_obs_t req_i,
  output bus_obs_t      bus_o
);
  // One-cycle strobe, no waits; idle lines toggle
  initial bus_o = '0;
  always @(posedge ref_clk_i) bus_o <= req_i.valid ? req_i : {1'b0, ~bus_o[27:0]};
endmodule
`default_nettype wire

//--- test/crc_snoop_tb_top.sv
// Testbench top for the snooping CRC unit
`timescale 1ns/10ps
`default_nettype none
module crc_snoop_tb_top;
  import crc_snoop_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, poly_crc16_i = 0, msb_first_i = 0, seed_we_i = 0, byte_we_i = 0, busy_o;
  logic [ADDR_W+1:0] snoop_target_address_i = '0;
  logic [15:0] seed_i = '0, checksum_result_o, exp_crc;
  logic [7:0] byte_i = '0, checksum_input_byte_o, exp_byte = '0;
  logic [9:0] a;
  logic [31:0] x;
  bus_obs_t bus_i, req = '0;
  int s = 93, err_total = 0, samples_checked = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  crc_bus_model crc_bus_model_inst (.ref_clk_i, .req_i(req), .bus_o(bus_i));
  crc_snoop crc_snoop_inst (.*);
  // Reference checksum, one byte
  function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] d);
    logic [15:0] g, r;
    g = poly_crc16_i ? POLY_CRC16 : POLY_CCITT;
    r = {<<{g}};
    for (int i = 0; i < 8; i++)
      c = msb_first_i ? (c << 1) ^ (c[15] ^ d[7-i] ? g : 16'h0000) : (c >> 1) ^ (c[0] ^ d[i] ? r : 16'h0000);
    return c;
  endfunction
  task ck(string name, logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Every mode: seed, then random explicit bytes and bus cycles
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1;
    repeat (3) @(posedge ref_clk_i);
    for (int m = 0; m < 4; m++) begin
      x = $random(s);
      poly_crc16_i <= m[0];
      msb_first_i <= m[1];
      snoop_target_address_i <= x[11:0];
      seed_we_i <= 1;
      seed_i <= x[31:16];
      exp_crc = x[31:16];
      @(posedge ref_clk_i) seed_we_i <= 0;
      repeat (40) begin
        x = $random(s);
        a = x[4] ? snoop_target_address_i[9:0] : x[14:5];
        a[0] = a[0] & !x[2];
        @(posedge ref_clk_i);
        if (x[1:0] == 0) begin
          byte_we_i <= 1;
          byte_i <= x[23:16];
          exp_byte = x[23:16];
          exp_crc = crc(exp_crc, x[23:16]);
        end else begin
          req <= {1'b1, x[3], x[2], a, x[31:16]};
          if ((x[3] ? snoop_target_address_i[WR_EN_BIT] : snoop_target_address_i[RD_EN_BIT])
              && (a == snoop_target_address_i[9:0] || x[2] && a + 10'h001 == snoop_target_address_i[9:0])) begin
            exp_byte = a == snoop_target_address_i[9:0] ? x[23:16] : x[31:24];
            exp_crc = crc(exp_crc, exp_byte);
          end
        end
        @(posedge ref_clk_i) begin byte_we_i <= 0; req.valid <= 0; end
        repeat (3) @(posedge ref_clk_i);
        #1 ck("checksum_result_o", checksum_result_o, exp_crc);
        ck("checksum_input_byte_o", {8'h00, checksum_input_byte_o}, {8'h00, exp_byte});
        ck("busy_o", {15'h0000, busy_o}, 16'h0000);
      end
    end
    results;
  end
  // Watchdog
  initial begin
    #100000;
    err_total++;
    results;
  end
endmodule
bind crc_snoop crc_snoop_props crc_snoop_props_inst (.*);
`default_nettype wire
